//--- rtl/sos_pkg.sv
// Package for the symbol output serializer: register map, field layouts,
// reset values, end-of-data actions and the serializer states.
// Assumes an 8-bit special-function-register bus from the embedded core.
package sos_pkg;

	// ==========================================================
	// Register offsets on the special-function-register bus
	localparam logic [7:0] SOS_ADDR_CONTROL = 8'ha9;
	localparam logic [7:0] SOS_ADDR_TIMING = 8'haa;
	localparam logic [7:0] SOS_ADDR_DATA = 8'hab;

	// ==========================================================
	// Reset values
	localparam logic [7:0] SOS_RST_CONTROL = 8'h00;
	localparam logic [7:0] SOS_RST_TIMING = 8'h00;
	localparam logic [7:0] SOS_RST_DATA = 8'h00;

	// ==========================================================
	// Timing constants, fill patterns and idle output codes
	localparam int SOS_RAMP_BASE = 8; // Ramp length in serializer clocks per edge step
	localparam logic [14:0] SOS_RATE_ONE = 15'h0001;
	localparam logic [7:0] SOS_ALL_ZERO = 8'h00;
	localparam logic [7:0] SOS_ALL_ONE = 8'hff;
	localparam logic [6:0] SOS_DEV_NONE = 7'h00;
	localparam logic [4:0] SOS_SLICE_NONE = 5'h00;

	// ==========================================================
	// End-of-data action, bits 7:6 of the control register
	typedef enum logic [1:0] {
		SOS_END_SHUTDOWN = 2'h0,
		SOS_END_REPEAT = 2'h1,
		SOS_END_ZEROS = 2'h2,
		SOS_END_ONES = 2'h3
	} sos_end_t;

	// Control register layout, msb first
	typedef struct packed {
		sos_end_t end_action;     // 7:6
		logic deviation_force;    // 5
		logic modulation_select;  // 4
		logic lc_osc_force_on;    // 3
		logic divider_force_on;   // 2
		logic amp_force_on;       // 1
		logic enable;             // 0
	} sos_ctrl_t;

	// Timing register layout, msb first
	typedef struct packed {
		logic [2:0] group_len;               // 7:5
		logic [1:0] edge_time;               // 4:3
		logic [2:0] serializer_clock_divisor; // 2:0
	} sos_timing_t;

	// Serializer sequence
	typedef enum {
		SOS_ST_IDLE,
		SOS_ST_RAMP_UP,
		SOS_ST_SEND,
		SOS_ST_RAMP_DOWN
	} sos_state_t;

endpackage : sos_pkg

//--- rtl/sos_serializer.sv
// Symbol output serializer: register file, clock divider, holding stage,
// shifter and power scheduling of amplifier, divider and LC oscillator.
// Assumes the core's register strobes and the data rate divisor, slice
// count and deviation code all come from logic on ref_clk_i.
`timescale 1ns/1ps

module sos_serializer (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic [14:0] data_rate_i,
	input wire logic [4:0] amp_slice_count_i,
	input wire logic [6:0] deviation_code_i,
	output logic holding_empty_o,
	output logic data_notify_o,
	output logic symbol_o,
	output logic amp_on_o,
	output logic amp_ramp_o,
	output logic [4:0] amp_slice_o,
	output logic divider_on_o,
	output logic lc_osc_on_o,
	output logic [6:0] freq_dev_o
);

	// ==========================================================
	// Register file
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
		addr_hit = (addr == off);
	endfunction : addr_hit

	sos_pkg::sos_ctrl_t ctrl_r, ctrl_nxt;
	sos_pkg::sos_timing_t timing_r, timing_nxt;
	logic [7:0] hold_r, hold_nxt;
	logic [2:0] hold_len_r, hold_len_nxt;
	logic hold_full_r, hold_full_nxt;
	logic notify_r, notify_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic data_wr;
	logic transfer;

	assign data_wr = sfr_wr_i && addr_hit(sfr_addr_i, sos_pkg::SOS_ADDR_DATA);

	// Writes, read mux and the holding stage; unmapped reads return zero
	always_comb begin
		ctrl_nxt = ctrl_r;
		timing_nxt = timing_r;
		hold_nxt = hold_r;
		hold_len_nxt = hold_len_r;
		hold_full_nxt = hold_full_r;
		rdata_nxt = rdata_r;
		notify_nxt = data_wr; // Registered, so it rises with the byte in place
		if (transfer) begin
			hold_full_nxt = 1'b0;
		end
		if (sfr_wr_i) begin
			if (addr_hit(sfr_addr_i, sos_pkg::SOS_ADDR_CONTROL)) begin
				ctrl_nxt = sos_pkg::sos_ctrl_t'(sfr_wdata_i);
			end else if (addr_hit(sfr_addr_i, sos_pkg::SOS_ADDR_TIMING)) begin
				timing_nxt = sos_pkg::sos_timing_t'(sfr_wdata_i);
			end else if (data_wr) begin
				hold_nxt = sfr_wdata_i;
				// Length is caught with the byte so later edits wait a group
				hold_len_nxt = timing_r.group_len;
				// A write landing on a transfer still leaves a new byte waiting
				hold_full_nxt = 1'b1;
			end
		end
		if (sfr_rd_i) begin
			if (addr_hit(sfr_addr_i, sos_pkg::SOS_ADDR_CONTROL)) begin
				rdata_nxt = ctrl_r;
			end else if (addr_hit(sfr_addr_i, sos_pkg::SOS_ADDR_TIMING)) begin
				rdata_nxt = timing_r;
			end else if (addr_hit(sfr_addr_i, sos_pkg::SOS_ADDR_DATA)) begin
				rdata_nxt = hold_r;
			end else begin
				rdata_nxt = sos_pkg::SOS_ALL_ZERO;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl_r <= sos_pkg::sos_ctrl_t'(sos_pkg::SOS_RST_CONTROL);
			timing_r <= sos_pkg::sos_timing_t'(sos_pkg::SOS_RST_TIMING);
			hold_r <= sos_pkg::SOS_RST_DATA;
			hold_len_r <= 3'h0;
			hold_full_r <= 1'b0;
			notify_r <= 1'b0;
			rdata_r <= sos_pkg::SOS_ALL_ZERO;
		end else begin
			ctrl_r <= ctrl_nxt;
			timing_r <= timing_nxt;
			hold_r <= hold_nxt;
			hold_len_r <= hold_len_nxt;
			hold_full_r <= hold_full_nxt;
			notify_r <= notify_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata_o = rdata_r;
	assign data_notify_o = notify_r;
	assign holding_empty_o = !hold_full_r;

	// ==========================================================
	// Serializer core
	sos_pkg::sos_state_t state_r, state_nxt;
	logic [2:0] ck_cnt_r, ck_cnt_nxt;
	logic [14:0] rate_cnt_r, rate_cnt_nxt;
	logic [4:0] ramp_cnt_r, ramp_cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] last_r, last_nxt;
	logic [2:0] len_r, len_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic ck_tick, sym_tick, group_end, sym;
	logic [14:0] rate_last;
	logic [4:0] ramp_last;
	logic amp_nxt, ramp_nxt, div_nxt, lc_nxt, sym_nxt;
	logic [4:0] slice_nxt;
	logic [6:0] dev_nxt;

	// Serializer clock is a strobe rather than a derived clock
	assign ck_tick = (ck_cnt_r == timing_r.serializer_clock_divisor);
	// A zero divisor is treated as one to avoid a stuck counter
	assign rate_last = (data_rate_i == 15'h0) ? 15'h0 : data_rate_i - sos_pkg::SOS_RATE_ONE;
	assign sym_tick = ck_tick && (rate_cnt_r == rate_last);
	// Ramp spans base times edge factor serializer clocks
	assign ramp_last = 5'(sos_pkg::SOS_RAMP_BASE * (int'(timing_r.edge_time) + 1) - 1);
	assign group_end = (idx_r == len_r); // Field plus one symbols
	assign sym = shift_r[idx_r]; // Bit zero goes first
	assign transfer = (state_r == sos_pkg::SOS_ST_IDLE && ctrl_r.enable && hold_full_r)
		|| (state_r == sos_pkg::SOS_ST_SEND && sym_tick && group_end && hold_full_r);

	// Sequence: ramp up, send groups, act on running dry; divider parked at idle unless forced on
	always_comb begin
		state_nxt = state_r;
		ck_cnt_nxt = (ck_tick || state_r == sos_pkg::SOS_ST_IDLE) ? 3'h0 : ck_cnt_r + 3'h1;
		rate_cnt_nxt = rate_cnt_r;
		ramp_cnt_nxt = ramp_cnt_r;
		shift_nxt = shift_r;
		last_nxt = last_r;
		len_nxt = len_r;
		idx_nxt = idx_r;
		case (state_r)
			sos_pkg::SOS_ST_IDLE: begin
				rate_cnt_nxt = 15'h0;
				ramp_cnt_nxt = 5'h0;
				if (transfer) begin
					shift_nxt = hold_r;
					last_nxt = hold_r;
					len_nxt = hold_len_r;
					idx_nxt = 3'h0;
					state_nxt = sos_pkg::SOS_ST_RAMP_UP;
				end
			end
			sos_pkg::SOS_ST_RAMP_UP: begin
				if (ck_tick) begin
					ramp_cnt_nxt = ramp_cnt_r + 5'h1;
					if (ramp_cnt_r == ramp_last) begin
						ramp_cnt_nxt = 5'h0;
						state_nxt = sos_pkg::SOS_ST_SEND;
					end
				end
			end
			sos_pkg::SOS_ST_SEND: begin
				if (ck_tick) begin
					rate_cnt_nxt = sym_tick ? 15'h0 : rate_cnt_r + 15'h1;
				end
				if (sym_tick) begin
					idx_nxt = idx_r + 3'h1;
					if (group_end) begin
						idx_nxt = 3'h0;
						if (hold_full_r) begin
							shift_nxt = hold_r; // Gapless hand-off
							last_nxt = hold_r;
							len_nxt = hold_len_r;
						end else begin
							case (ctrl_r.end_action)
								sos_pkg::SOS_END_SHUTDOWN: state_nxt = sos_pkg::SOS_ST_RAMP_DOWN;
								sos_pkg::SOS_END_REPEAT: shift_nxt = last_r;
								sos_pkg::SOS_END_ZEROS: shift_nxt = sos_pkg::SOS_ALL_ZERO;
								default: shift_nxt = sos_pkg::SOS_ALL_ONE;
							endcase
						end
					end
				end
			end
			sos_pkg::SOS_ST_RAMP_DOWN: begin
				if (ck_tick) begin
					ramp_cnt_nxt = ramp_cnt_r + 5'h1;
					if (ramp_cnt_r == ramp_last) begin
						ramp_cnt_nxt = 5'h0;
						state_nxt = sos_pkg::SOS_ST_IDLE;
					end
				end
			end
			default: state_nxt = sos_pkg::SOS_ST_IDLE;
		endcase
		if (!ctrl_r.enable) begin
			state_nxt = sos_pkg::SOS_ST_IDLE;
		end
	end

	// Output stage; every data output comes from a flip-flop
	always_comb begin
		sym_nxt = (state_r == sos_pkg::SOS_ST_SEND) && sym;
		// On-off keys the amplifier per symbol, frequency shift holds it on
		amp_nxt = (state_r == sos_pkg::SOS_ST_RAMP_UP)
			|| (state_r == sos_pkg::SOS_ST_SEND && (ctrl_r.modulation_select || sym));
		ramp_nxt = (state_r == sos_pkg::SOS_ST_RAMP_UP) || (state_r == sos_pkg::SOS_ST_RAMP_DOWN);
		// Divider and oscillator sleep whenever the sequence is idle and their force bits are clear
		div_nxt = (state_r != sos_pkg::SOS_ST_IDLE) || ctrl_r.divider_force_on;
		lc_nxt = (state_r != sos_pkg::SOS_ST_IDLE) || ctrl_r.lc_osc_force_on;
		slice_nxt = amp_nxt ? amp_slice_count_i : sos_pkg::SOS_SLICE_NONE;
		if (ctrl_r.amp_force_on) begin
			amp_nxt = 1'b1;
			slice_nxt = amp_slice_count_i;
		end
		dev_nxt = sos_pkg::SOS_DEV_NONE;
		if (ctrl_r.deviation_force) begin
			dev_nxt = deviation_code_i;
		end else if (ctrl_r.modulation_select && sym_nxt) begin
			dev_nxt = deviation_code_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_r <= sos_pkg::SOS_ST_IDLE;
			ck_cnt_r <= 3'h0;
			rate_cnt_r <= 15'h0;
			ramp_cnt_r <= 5'h0;
			shift_r <= sos_pkg::SOS_ALL_ZERO;
			last_r <= sos_pkg::SOS_ALL_ZERO;
			len_r <= 3'h0;
			idx_r <= 3'h0;
			symbol_o <= 1'b0;
			amp_on_o <= 1'b0;
			amp_ramp_o <= 1'b0;
			amp_slice_o <= sos_pkg::SOS_SLICE_NONE;
			divider_on_o <= 1'b0;
			lc_osc_on_o <= 1'b0;
			freq_dev_o <= sos_pkg::SOS_DEV_NONE;
		end else begin
			state_r <= state_nxt;
			ck_cnt_r <= ck_cnt_nxt;
			rate_cnt_r <= rate_cnt_nxt;
			ramp_cnt_r <= ramp_cnt_nxt;
			shift_r <= shift_nxt;
			last_r <= last_nxt;
			len_r <= len_nxt;
			idx_r <= idx_nxt;
			symbol_o <= sym_nxt;
			amp_on_o <= amp_nxt;
			amp_ramp_o <= ramp_nxt;
			amp_slice_o <= slice_nxt;
			divider_on_o <= div_nxt;
			lc_osc_on_o <= lc_nxt;
			freq_dev_o <= dev_nxt;
		end
	end

	// ==========================================================
	// Assertions
	AST_NOTIFY_ONCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		data_wr |=> data_notify_o && hold_r == $past(sfr_wdata_i))
		else $error("Data write gave no notify pulse with stable byte");
	AST_NOTIFY_CAUSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		data_notify_o |-> $past(data_wr))
		else $error("Notify pulse without a data write");
	AST_EMPTY_CLEAR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		data_wr |=> !holding_empty_o)
		else $error("Data write did not clear the empty flag");
	AST_EMPTY_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(transfer && !data_wr) |=> holding_empty_o)
		else $error("Transfer to shifter did not set the empty flag");
	AST_DISABLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ctrl_r.enable |=> state_r == sos_pkg::SOS_ST_IDLE ##1 !amp_ramp_o)
		else $error("Serializer kept running while disabled");
	AST_FORCE_AMP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctrl_r.amp_force_on |=> amp_on_o && amp_slice_o == $past(amp_slice_count_i))
		else $error("Amplifier force did not hold amp on with slices");
	AST_FORCE_UNITS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(ctrl_r.lc_osc_force_on && ctrl_r.divider_force_on) |=> lc_osc_on_o && divider_on_o)
		else $error("Force bits did not hold oscillator and divider on");
	AST_IDLE_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state_r == sos_pkg::SOS_ST_IDLE && !ctrl_r.divider_force_on) |=> !divider_on_o)
		else $error("Divider powered while idle");
	AST_DEV_FORCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctrl_r.deviation_force |=> freq_dev_o == $past(deviation_code_i))
		else $error("Deviation force not applied");
	AST_OOK_KEY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state_r == sos_pkg::SOS_ST_SEND && !ctrl_r.modulation_select
			&& !ctrl_r.amp_force_on) |=> amp_on_o == symbol_o)
		else $error("On-off keying does not follow the symbol");
	AST_SHUTDOWN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state_r == sos_pkg::SOS_ST_SEND && sym_tick && group_end && !hold_full_r
			&& ctrl_r.enable && ctrl_r.end_action == sos_pkg::SOS_END_SHUTDOWN)
		|=> state_r == sos_pkg::SOS_ST_RAMP_DOWN)
		else $error("Running dry did not start shutdown");
	AST_CK_DIV: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(ck_tick && $stable(timing_r)) |=> ck_cnt_r == 3'h0)
		else $error("Clock divider did not restart after its strobe");

	COV_SEND: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sos_pkg::SOS_ST_RAMP_UP ##1 state_r == sos_pkg::SOS_ST_SEND);
	COV_GAPLESS: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sos_pkg::SOS_ST_SEND && transfer);
	COV_REPEAT: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sos_pkg::SOS_ST_SEND && sym_tick && group_end && !hold_full_r
		&& ctrl_r.end_action == sos_pkg::SOS_END_REPEAT);
	COV_DOWN: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sos_pkg::SOS_ST_RAMP_DOWN ##1 state_r == sos_pkg::SOS_ST_IDLE);

endmodule : sos_serializer

//--- verif/sos_core_model.sv
// Behavioural model of the embedded core that reaches the serializer's registers.
// Assumes the bench calls access at a falling edge and ref_clk_i runs freely.
`timescale 1ns/1ps
module sos_core_model (
	input wire logic ref_clk_i,
	output logic [7:0] sfr_addr_o,
	output logic sfr_wr_o,
	output logic sfr_rd_o,
	output logic [7:0] sfr_wdata_o,
	input wire logic [7:0] sfr_rdata_i
);
	// ==========================================================
	// Bus idle state at time zero
	initial begin
		sfr_addr_o = 8'h00;
		sfr_wr_o = 1'b0;
		sfr_rd_o = 1'b0;
		sfr_wdata_o = 8'h00;
	end

	// ==========================================================
	// One bus cycle: launched on a falling edge, taken on the next rising edge
	// Gap adds idle cycles for a slow core; at least one idle edge always passes
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdat,
		input int gap, output logic [7:0] rdat);
		repeat (gap + 1) @(negedge ref_clk_i);
		sfr_addr_o = addr;
		sfr_wdata_o = wdat;
		sfr_wr_o = wr;
		sfr_rd_o = !wr;
		@(negedge ref_clk_i);
		sfr_wr_o = 1'b0;
		sfr_rd_o = 1'b0;
		// Released bus shows inverted values so stale data cannot pass for fresh
		sfr_addr_o = ~addr;
		sfr_wdata_o = ~wdat;
		rdat = sfr_rdata_i;
	endtask : access
endmodule : sos_core_model

//--- verif/tb_top.sv
// Self-checking bench for the symbol output serializer.
// Assumes the core model above drives the register bus; other inputs are levels.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdat;
		logic [7:0] exp;
	} sos_row_t;
	localparam logic [14:0] RATE = 15'h0003;
	localparam logic [4:0] SLICE = 5'h15;
	localparam logic [6:0] DEVC = 7'h5a;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_o, rd;
	logic sfr_wr, sfr_rd, holding_empty_o, data_notify_o, symbol_o, amp_on_o, amp_ramp_o;
	logic divider_on_o, lc_osc_on_o;
	logic [4:0] amp_slice_o;
	logic [6:0] freq_dev_o;
	int n_errors = 0;
	int n_checks = 0;
	sos_row_t rows [8] = '{'{1'b0, 8'ha9, 8'h00, 8'h00}, '{1'b0, 8'haa, 8'h00, 8'h00},
		'{1'b0, 8'hab, 8'h00, 8'h00}, '{1'b1, 8'haa, 8'he5, 8'he5},
		'{1'b1, 8'hab, 8'ha5, 8'ha5}, '{1'b1, 8'ha8, 8'h77, 8'h00},
		'{1'b1, 8'hac, 8'h77, 8'h00}, '{1'b1, 8'ha9, 8'h3e, 8'h3e}};

	// ==========================================================
	// Clock, design and core model
	initial begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	sos_serializer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr),
		.sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata),
		.sfr_rdata_o(sfr_rdata_o), .data_rate_i(RATE), .amp_slice_count_i(SLICE),
		.deviation_code_i(DEVC), .holding_empty_o(holding_empty_o),
		.data_notify_o(data_notify_o), .symbol_o(symbol_o), .amp_on_o(amp_on_o),
		.amp_ramp_o(amp_ramp_o), .amp_slice_o(amp_slice_o), .divider_on_o(divider_on_o),
		.lc_osc_on_o(lc_osc_on_o), .freq_dev_o(freq_dev_o));
	sos_core_model core (.ref_clk_i(ref_clk_i), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr),
		.sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata), .sfr_rdata_i(sfr_rdata_o));

	// ==========================================================
	// Compare and closing tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_n(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			n_errors++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_n
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// One transmission: ramp length, each symbol, then the end-of-data action
	task automatic run_group(input logic [7:0] ctrl, input logic [7:0] tim,
		input logic [7:0] dat);
		int s_len, g_len, n;
		logic e;
		s_len = RATE * (tim[2:0] + 1);
		g_len = tim[7:5] + 1;
		core.access(1'b1, 8'haa, tim, 1, rd);
		core.access(1'b1, 8'hab, dat, 0, rd);
		core.access(1'b1, 8'ha9, ctrl, 2, rd);
		n = 0;
		while (amp_ramp_o !== 1'b1 && n < 200) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk("empty", 8'h01, 8'(holding_empty_o));
		n = 0;
		while (amp_ramp_o === 1'b1 && n < 300) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk_n("ramp", 8 * (tim[4:3] + 1) * (tim[2:0] + 1), n);
		// Sample mid-symbol so a one-cycle launch offset cannot flip the result
		repeat (s_len / 2) @(negedge ref_clk_i);
		for (int i = 0; i < (ctrl[7:6] == 2'h0 ? g_len : g_len + 3); i++) begin
			e = (i < g_len || ctrl[7:6] == 2'h1) ? dat[i % g_len] : ctrl[7:6] == 2'h3;
			chk("symbol", 8'(e), 8'(symbol_o));
			chk("amp", 8'(ctrl[4] | e), 8'(amp_on_o));
			chk("dev", 8'(ctrl[4] && e ? DEVC : 7'h00), 8'(freq_dev_o));
			repeat (s_len) @(negedge ref_clk_i);
		end
		n = 0;
		while (ctrl[7:6] == 2'h0 && lc_osc_on_o !== 1'b0 && n < 400) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (ctrl[7:6] == 2'h0) begin
			chk("powered", 8'h00, 8'({amp_on_o, divider_on_o, lc_osc_on_o}));
		end
		core.access(1'b1, 8'ha9, 8'h00, 0, rd);
		repeat (2) @(negedge ref_clk_i);
		chk("off", 8'h00, 8'({amp_on_o, symbol_o, amp_ramp_o}));
		$display("test group %h done", ctrl);
	endtask : run_group

	// ==========================================================
	// Watchdog: far beyond the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_errors++;
		final_report();
	end

	// ==========================================================
	// Main sequence: register rows, then hand-written cases
	initial begin
		repeat (4) @(negedge ref_clk_i);
		rst_i = 1'b0;
		chk("empty", 8'h01, 8'(holding_empty_o));
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				core.access(1'b1, rows[i].addr, rows[i].wdat, 0, rd);
			end
			core.access(1'b0, rows[i].addr, 8'h00, 0, rd);
			chk("reg", rows[i].exp, rd);
		end
		$display("test registers done");
		chk("forced", 8'h07, 8'({amp_on_o, divider_on_o, lc_osc_on_o}));
		chk("slice", 8'(SLICE), 8'(amp_slice_o));
		chk("dev", 8'(DEVC), 8'(freq_dev_o));
		core.access(1'b1, 8'ha9, 8'h00, 0, rd);
		repeat (2) @(negedge ref_clk_i);
		chk("released", 8'h00, 8'({divider_on_o, lc_osc_on_o}));
		$display("test forcing done");
		core.access(1'b1, 8'hab, 8'h3c, 0, rd);
		chk("notify", 8'h01, 8'(data_notify_o));
		chk("empty", 8'h00, 8'(holding_empty_o));
		@(negedge ref_clk_i);
		chk("notify", 8'h00, 8'(data_notify_o));
		$display("test notify done");
		run_group(8'h81, 8'h89, 8'hed);
		run_group(8'hd1, 8'he1, 8'h36);
		run_group(8'h41, 8'h20, 8'h02);
		run_group(8'h01, 8'h9f, 8'h0b);
		core.access(1'b1, 8'ha9, 8'h0e, 0, rd);
		rst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		rst_i = 1'b0;
		chk("reset", 8'h01, 8'({lc_osc_on_o, amp_on_o, holding_empty_o}));
		core.access(1'b0, 8'ha9, 8'h00, 0, rd);
		chk("reg", 8'h00, rd);
		$display("test reset done");
		final_report();
	end
endmodule : tb_top
